// ### pms_port_mode.sv
`timescale 1ns/1ps
`include "pms_map.svh"
// Contract
// - Logic-array, data-port, address-in, pattern modes fixed
// - Ports E-G control bit 0 gives host I/O
// - Direction bit 1 output, 0 input
// - Output pin driven from output data register
// - Input buffer read returns live pin level
// - Ports A-C no control, host I/O default
// - Logic-array mode feeds inputs, drives outputs on ports A-D only
// - Address out needs array enable or dir&ctrl
// - E/F carry A7:0, G carries A15:8
// - High address inputs routed, optionally strobe-latched
// - Decode-equation inputs treated as address inputs
// - Data port F/G disables general I/O
// - Non-multiplexed host selects data port automatically
// - Port E offers JTAG programming access
// - Pattern mode only F/G, one host family
// - Pattern driven in reset when bus idle
// - All configuration registers reset to 00h
// - Output data register reads back
// - Port D only four direction bits active

module pms_port_mode (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pms_pkg::pms_cfg_t cfg_in,
	input wire pms_pkg::pms_host_t host,
	input wire pms_pkg::pms_port_vec_t pin_in,
	input wire pms_pkg::pms_port_vec_t la_out,
	input wire pms_pkg::pms_port_vec_t la_oe,
	input wire logic jtag_tdo,
	input wire logic jtag_tdo_oe,
	output pms_pkg::pms_pin_drv_t pin_drv,
	output pms_pkg::pms_port_vec_t to_logic_array,
	output logic [15:0] host_wdata,
	output logic jtag_tck,
	output logic jtag_tms,
	output logic jtag_tdi
);
	import pms_pkg::*;

	// ---------------------------------------------------------------
	// Configuration capture
	// ---------------------------------------------------------------
	pms_cfg_t cfg;
	logic cfg_taken;

	// Programmed modes are sampled once after reset and then held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= '0;
			cfg_taken <= 1'b0;
		end else if (!cfg_taken) begin
			cfg <= cfg_in;
			cfg_taken <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Port registers
	// ---------------------------------------------------------------
	pms_port_vec_t data_out;
	pms_port_vec_t dir;
	pms_port_vec_t ctrl;
	logic [2:0] sel_port;
	logic [1:0] sel_reg;
	logic mapped;
	logic access;
	logic [7:0] port_mask;
	logic [7:0] next_rdata;
	logic in_page;
	logic port_ok;
	logic aligned;

	assign sel_port = paddr[`PMS_ADDR_PORT_LSB +: 3];
	assign sel_reg = paddr[`PMS_ADDR_REG_LSB +: 2];
	// Foreign pages, port 7 and misaligned words are refused
	assign in_page = (paddr[11:7] == 5'h00);
	assign port_ok = (sel_port != 3'd7);
	assign aligned = (paddr[1:0] == 2'h0);
	assign mapped = in_page && port_ok && aligned;
	assign access = psel && penable && !pready;
	assign port_mask = (sel_port == `PMS_PORT_D) ? `PMS_PORT_D_MASK : `PMS_FULL_MASK;

	// Register writes; control bits exist only on ports E, F and G
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out <= {`PMS_NPORT{`PMS_REG_RESET}};
			dir <= {`PMS_NPORT{`PMS_REG_RESET}};
			ctrl <= {`PMS_NPORT{`PMS_REG_RESET}};
		end else if (access && pwrite && mapped) begin
			unique case (sel_reg)
				`PMS_OFS_DATA_OUT: data_out[sel_port] <= pwdata[7:0] & port_mask;
				`PMS_OFS_DIR: dir[sel_port] <= pwdata[7:0] & port_mask;
				`PMS_OFS_CTRL: begin
					if (sel_port >= `PMS_PORT_E) begin
						ctrl[sel_port] <= pwdata[7:0];
					end
				end
				`PMS_OFS_DATA_IN: ;
			endcase
		end
	end

	// Read mux
	always_comb begin
		next_rdata = 8'h00;
		if (mapped) begin
			unique case (sel_reg)
				`PMS_OFS_DATA_IN: next_rdata = pin_in[sel_port] & port_mask;
				`PMS_OFS_DATA_OUT: next_rdata = data_out[sel_port];
				`PMS_OFS_DIR: next_rdata = dir[sel_port];
				`PMS_OFS_CTRL: next_rdata = (sel_port >= `PMS_PORT_E) ? ctrl[sel_port] : 8'h00;
			endcase
		end
	end

	// APB answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
			if (access && !pwrite) begin
				prdata <= {24'h000000, next_rdata};
			end
		end
	end

	// ---------------------------------------------------------------
	// Address latching
	// ---------------------------------------------------------------
	logic [15:0] addr_q;
	pms_port_vec_t pin_latched;
	logic pattern_on;
	logic pattern_allowed;

	// Bus address and address-in pins captured on the strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= '0;
			pin_latched <= '0;
		end else if (host.addr_strobe) begin
			addr_q <= host.addr;
			pin_latched <= pin_in;
		end
	end

	// Pattern drive only for the one host family on the data port
	assign pattern_allowed = cfg.rst_pat_en && cfg.reset_family && cfg.nonmux;
	assign pattern_on = pattern_allowed && host.rst_active && !host.bus_cycle;

	// ---------------------------------------------------------------
	// Per-pin output multiplexer
	// ---------------------------------------------------------------
	pms_pin_drv_t next_drv;
	pms_port_vec_t next_to_array;

	for (genvar p = 0; p < `PMS_NPORT; p++) begin : g_port
		for (genvar b = 0; b < 8; b++) begin : g_bit
			localparam bit HAS_CTRL = (p >= 4);
			localparam bit IS_DATA = (p >= 5);
			localparam bit IS_JTAG = (p == 4) && (b <= `PMS_TDO_PIN);
			localparam bit IS_ADDR_IN = (p != 4) && (p != 6);
			localparam bit PIN_EXISTS = (p != 3) || (b < 4);
			localparam bit BURST_GAP = (p == 4 || p == 5) && (b < `PMS_BURST_LOW_BITS);
			localparam int ADDR_BIT = (p == 6) ? (b + 8) : b;
			localparam int DATA_BIT = (p == 6) ? (b + 8) : b;
			logic addr_pin;
			logic addr_en;

			assign addr_pin = IS_ADDR_IN && cfg.addr_in[p][b];
			assign addr_en = HAS_CTRL && ((ctrl[p][b] && dir[p][b]) || la_oe[p][b])
				&& !(BURST_GAP && cfg.burst_host);

			// Pick exactly one source in priority of the fixed modes
			always_comb begin
				next_drv.out[p][b] = 1'b0;
				next_drv.oe[p][b] = 1'b0;
				if (!PIN_EXISTS) begin
					next_drv.oe[p][b] = 1'b0;
				end else if (IS_JTAG && cfg.jtag_en) begin
					if (b == `PMS_TDO_PIN) begin
						next_drv.out[p][b] = jtag_tdo;
						next_drv.oe[p][b] = jtag_tdo_oe;
					end
				end else if (IS_DATA && cfg.nonmux) begin
					if (pattern_on) begin
						next_drv.out[p][b] = cfg.rst_pattern[DATA_BIT];
						next_drv.oe[p][b] = 1'b1;
					end else begin
						next_drv.out[p][b] = host.rdata[DATA_BIT];
						next_drv.oe[p][b] = host.rd_oe;
					end
				end else if (cfg.pld_out[p][b] && !HAS_CTRL) begin
					next_drv.out[p][b] = la_out[p][b];
					next_drv.oe[p][b] = la_oe[p][b];
				end else if (HAS_CTRL && ctrl[p][b]) begin
					next_drv.out[p][b] = addr_q[ADDR_BIT];
					next_drv.oe[p][b] = addr_en;
				end else if (!cfg.pld_in[p][b] && !addr_pin) begin
					next_drv.out[p][b] = data_out[p][b];
					next_drv.oe[p][b] = dir[p][b];
				end
			end

			// Pin level, or strobe-latched level, toward the logic arrays
			always_comb begin
				if (addr_pin && cfg.addr_latch) begin
					next_to_array[p][b] = pin_latched[p][b];
				end else begin
					next_to_array[p][b] = pin_in[p][b] & PIN_EXISTS;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------

	// Pin drive, released after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_drv <= '0;
		end else begin
			pin_drv <= next_drv;
		end
	end

	// Inputs toward logic arrays and host data bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_logic_array <= '0;
			host_wdata <= '0;
		end else begin
			to_logic_array <= next_to_array;
			host_wdata <= cfg.nonmux ? {pin_in[`PMS_PORT_G], pin_in[`PMS_PORT_F]} : 16'h0000;
		end
	end

	// Test-port inputs from port E
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jtag_tck <= 1'b0;
			jtag_tms <= 1'b0;
			jtag_tdi <= 1'b0;
		end else begin
			jtag_tck <= cfg.jtag_en && pin_in[`PMS_PORT_E][`PMS_TCK_PIN];
			jtag_tms <= cfg.jtag_en && pin_in[`PMS_PORT_E][`PMS_TMS_PIN];
			jtag_tdi <= cfg.jtag_en && pin_in[`PMS_PORT_E][`PMS_TDI_PIN];
		end
	end

endmodule

// ### pms_map.svh
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// ---------------------------------------------------------------
// Port indices
// ---------------------------------------------------------------
`define PMS_PORT_A 3'd0
`define PMS_PORT_B 3'd1
`define PMS_PORT_C 3'd2
`define PMS_PORT_D 3'd3
`define PMS_PORT_E 3'd4
`define PMS_PORT_F 3'd5
`define PMS_PORT_G 3'd6
`define PMS_NPORT 7

// ---------------------------------------------------------------
// Register map: byte offset = port * stride + 4 * register offset
// ---------------------------------------------------------------
`define PMS_PORT_STRIDE 12'h010
`define PMS_OFS_DATA_IN 2'h0
`define PMS_OFS_DATA_OUT 2'h1
`define PMS_OFS_DIR 2'h2
`define PMS_OFS_CTRL 2'h3
`define PMS_ADDR_PORT_LSB 4
`define PMS_ADDR_REG_LSB 2

// ---------------------------------------------------------------
// Reset values and field layouts
// ---------------------------------------------------------------
`define PMS_REG_RESET 8'h00
`define PMS_FULL_MASK 8'hff
`define PMS_PORT_D_MASK 8'h0f
`define PMS_TDO_PIN 3
`define PMS_TMS_PIN 0
`define PMS_TCK_PIN 1
`define PMS_TDI_PIN 2
`define PMS_BURST_LOW_BITS 4

`endif

// ### pms_pkg.sv
package pms_pkg;

	// Per-pin bit vectors for all seven ports
	typedef logic [6:0][7:0] pms_port_vec_t;

	// Programmed configuration, fixed once captured after reset
	typedef struct packed {
		pms_port_vec_t pld_in;
		pms_port_vec_t pld_out;
		pms_port_vec_t addr_in;
		logic addr_latch;
		logic nonmux;
		logic burst_host;
		logic reset_family;
		logic rst_pat_en;
		logic jtag_en;
		logic [15:0] rst_pattern;
	} pms_cfg_t;

	// Pin drive bundle
	typedef struct packed {
		pms_port_vec_t out;
		pms_port_vec_t oe;
	} pms_pin_drv_t;

	// Host-side signals of the data port
	typedef struct packed {
		logic rst_active;
		logic bus_cycle;
		logic rd_oe;
		logic [15:0] rdata;
		logic [15:0] addr;
		logic addr_strobe;
	} pms_host_t;

endpackage

// ### pms_pin_model.sv
`timescale 1ns/1ps
// ------------------------------
// Pin-side model of the board
// ------------------------------
module pms_pin_model (
	input wire logic pclk,
	input wire pms_pkg::pms_pin_drv_t drv,
	input wire pms_pkg::pms_port_vec_t ext,
	input wire pms_pkg::pms_port_vec_t ext_en,
	output pms_pkg::pms_port_vec_t pins
);
	import pms_pkg::*;
	pms_port_vec_t last = '0;
	// Floating lines move away from their last level
	always_ff @(posedge pclk) begin
		last <= pins;
	end
	// Device drive first, then board drive, else floating
	always_comb begin
		pins = (drv.out & drv.oe) | (ext & ext_en & ~drv.oe) | (~last & ~ext_en & ~drv.oe);
	end
endmodule

// ### pms_port_mode_assertions.sv
`timescale 1ns/1ps
module pms_port_mode_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire pms_pkg::pms_cfg_t cfg_in,
	input wire pms_pkg::pms_pin_drv_t pin_drv,
	input wire logic [15:0] host_wdata
);
	import pms_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------
	// Bus answer and pin timing
	// ------------------------------
	sequence s_acc; psel && penable && !pready; endsequence
	sequence s_ans; psel && penable && pready; endsequence
	sequence s_wr; pready && pwrite; endsequence
	property p_wait; s_acc |=> s_ans; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_err; pready |-> pslverr == (paddr[11:7] != 5'h0 || paddr[6:4] == 3'h7 || paddr[1:0] != 2'h0); endproperty
	property p_rdz; prdata[31:8] == 24'h0; endproperty
	property p_dmask; pin_drv.oe[3][7:4] == 4'h0; endproperty
	property p_hw; !cfg_in.nonmux |-> host_wdata == 16'h0; endproperty
	property p_oe; !cfg_in.pld_out[0][0] && $rose(pin_drv.oe[0][0]) |-> $past(pready && pwrite); endproperty
	property p_goe; (s_wr and (paddr[6:4] != 3'h6)) |=> !$rose(pin_drv.oe[6][0]); endproperty
	a_wait: assert property (p_wait) else $error("answer late");
	a_pulse: assert property (p_pulse) else $error("answer too long");
	a_err: assert property (p_err) else $error("error flag wrong");
	a_rdz: assert property (p_rdz) else $error("read upper bits set");
	a_dmask: assert property (p_dmask) else $error("absent pin driven");
	a_hw: assert property (p_hw) else $error("data port active");
	a_oe: assert property (p_oe) else $error("drive without write");
	a_goe: assert property (p_goe) else $error("address pin drive wrong");
endmodule
bind pms_port_mode pms_port_mode_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .cfg_in, .pin_drv, .host_wdata);

// ### port_mode_selection_tb_top.sv
`timescale 1ns/1ps
module port_mode_selection_tb_top;
	import pms_pkg::*;
	typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] e;} pms_row_t;
	logic pclk, pready, pslverr, err;
	logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [15:0] host_wdata;
	logic jtag_tdo = 1'b0, jtag_tdo_oe = 1'b0, tck, tms, tdi;
	pms_cfg_t cfg_in = '0; // No logic-array pins, so no direction conflict
	pms_host_t host = '0;
	pms_port_vec_t pin_in, to_la, la_out = '0, la_oe = '0, ext = '0, ext_en = '0;
	pms_pin_drv_t pin_drv;
	int n_fail = 0;
	int total_checks = 0;
	pms_row_t rows [7] = '{{12'h004, 8'h5a, 8'h5a}, {12'h008, 8'h0f, 8'h0f}, {12'h038, 8'hff, 8'h0f},
		{12'h00c, 8'hff, 8'h00}, {12'h04c, 8'h81, 8'h81}, {12'h068, 8'h3c, 8'h3c}, {12'h070, 8'h77, 8'h00}};
	pms_port_mode dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cfg_in, .host, .pin_in, .la_out, .la_oe, .jtag_tdo, .jtag_tdo_oe, .pin_drv,
		.to_logic_array(to_la), .host_wdata, .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi));
	pms_pin_model u_pins (.pclk, .drv(pin_drv), .ext, .ext_en, .pins(pin_in));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic test_done();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One bus transfer, held until the answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 8);
		if (pready !== 1'b1) begin
			n_fail++;
			test_done();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 1; k < 4; k++) begin
			apb(1'b0, 12'h040 + 12'(k * 4), 8'h0);
			chk(rd, 32'h0);
		end
		chk(32'(pin_drv.oe != '0), 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 8'h0);
			chk(rd, {24'h0, rows[i].e});
			chk(32'(err), 32'(rows[i].a[6:4] == 3'h7));
		end
		$display("test rows done");
		repeat (2) @(posedge pclk);
		chk({24'h0, pin_drv.oe[0]}, 32'h0f);
		chk({28'h0, pin_drv.out[0][3:0]}, 32'ha);
		chk({24'h0, pin_drv.oe[3]}, 32'h0f);
		chk({24'h0, pin_drv.oe[4]}, 32'h0);
		ext[1] <= 8'ha5;
		ext_en[1] <= 8'hff;
		repeat (3) @(posedge pclk);
		apb(1'b0, 12'h010, 8'h0);
		chk(rd, 32'ha5);
		$display("test pins done");
		host.addr <= 16'h5abd;
		host.addr_strobe <= 1'b1;
		apb(1'b1, 12'h048, 8'hff);
		apb(1'b1, 12'h06c, 8'hff);
		repeat (2) @(posedge pclk);
		chk({24'h0, pin_drv.out[4]}, 32'h81);
		chk({24'h0, pin_drv.oe[6]}, 32'h3c);
		chk({24'h0, pin_drv.out[6] & pin_drv.oe[6]}, 32'h18);
		$display("test address done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 8'h0);
		chk(rd, 32'h0);
		chk(32'(pin_drv.oe != '0), 32'h0);
		$display("test rereset done");
		presetn <= 1'b0;
		cfg_in <= '{default: '0, pld_out: 56'hf0, addr_in: 56'hff00, addr_latch: 1'b1, nonmux: 1'b1,
			reset_family: 1'b1, rst_pat_en: 1'b1, jtag_en: 1'b1, rst_pattern: 16'hc35a};
		host <= '{default: '0, rst_active: 1'b1};
		jtag_tdo <= 1'b1;
		jtag_tdo_oe <= 1'b1;
		la_out[0] <= 8'h96;
		la_oe[0] <= 8'hf0;
		ext[4] <= 8'h07;
		ext_en[4] <= 8'hff;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({pin_drv.out[6], pin_drv.out[5], pin_drv.oe[6], pin_drv.oe[5]}, 32'hc35affff);
		chk({16'h0, pin_drv.oe[4], 4'h0, pin_drv.out[4][3], tck, tms, tdi}, 32'h0000080f);
		chk({16'h0, pin_drv.oe[0], pin_drv.out[0] & pin_drv.oe[0]}, 32'h0000f090);
		host <= '{default: '0, rd_oe: 1'b1, rdata: 16'h1234};
		repeat (2) @(posedge pclk);
		chk({pin_drv.out[6], pin_drv.out[5], pin_drv.oe[6], pin_drv.oe[5]}, 32'h1234ffff);
		host <= '{default: '0, addr_strobe: 1'b1};
		ext <= 56'h88770700003c00;
		ext_en <= 56'hffffff0000ff00;
		repeat (3) @(posedge pclk);
		chk({16'h0, host_wdata}, 32'h8877);
		host.addr_strobe <= 1'b0;
		ext[1] <= 8'hc3;
		repeat (3) @(posedge pclk);
		chk({16'h0, to_la[1], to_la[5]}, 32'h3c77);
		apb(1'b1, 12'h018, 8'hff);
		repeat (2) @(posedge pclk);
		chk({24'h0, pin_drv.oe[1]}, 32'h0);
		$display("test modes done");
		presetn <= 1'b0;
		cfg_in <= '{default: '0, burst_host: 1'b1};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h04c, 8'hff);
		apb(1'b1, 12'h048, 8'hff);
		repeat (2) @(posedge pclk);
		chk({24'h0, pin_drv.oe[4]}, 32'hf0);
		$display("test burst done");
		test_done();
	end
endmodule
